// ==== verilog/scc_pkg.sv ====
// Constants, register map and CRC helpers for the serial command layer.
package scc_pkg;

  // Register addresses (one byte each, 4-bit address space)
  localparam logic [3:0] ADDR_REV     = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  localparam logic [3:0] ADDR_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_CFG4    = 4'h7;
  localparam logic [3:0] ADDR_MAP_CRC = 4'hf;
  localparam logic [3:0] ADDR_LAST    = 4'hf;
  localparam int         NUM_REGS     = 16;

  // Span covered by the register map check
  localparam int MAP_FIRST = 0;
  localparam int MAP_LAST  = 14;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // Status byte fields
  localparam int ST_SPI_ERR = 0;
  localparam int ST_REG_ERR = 1;

  // Configuration register four fields
  localparam int CFG_SPI_CRC   = 0;
  localparam int CFG_REG_CRC   = 1;
  localparam int CFG_STATUS_EN = 2;
  localparam int CFG_RES16     = 3;

  // Command encodings, upper nibble of the first command byte
  localparam logic [3:0] CMD_READ_NIB  = 4'h4;
  localparam logic [3:0] CMD_WRITE_NIB = 4'h8;

  // Frame sizes in bits
  localparam logic [7:0] CMD_BITS     = 8'h10;
  localparam logic [7:0] CMD_CRC_BITS = 8'h18;
  localparam logic [5:0] CRC_LEN_BITS = 6'h08;
  localparam logic [5:0] BITS_16      = 6'h10;
  localparam logic [5:0] BITS_24      = 6'h18;
  localparam logic [5:0] BITS_32      = 6'h20;

  // CRC: polynomial 1_0000_0111, leading byte inverted
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;

  // One MSB-first step of the division
  function automatic logic [7:0] scc_crc_bit(input logic [7:0] c, input logic b);
    scc_crc_bit = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

endpackage

// ==== verilog/scc_top.sv ====
// Serial command decoder with link CRC and register map CRC check.
`timescale 1ns/100ps

// Function
// - With link CRC enabled, commands carry a CRC byte and output frames append one.
// - CRC mismatch blocks the command and sets the transfer error flag.
// - Transfer error blocks writes except status; writing one clears the flag.
// - Reads still run under transfer error; only a bad read frame is dropped.
// - Output CRC covers every byte sent before it in the frame.
// - CRC is remainder by x^8+x^2+x+1.
// - Leading byte of the CRC argument is inverted first.
// - Argument extended by eight zeros, divided until remainder below 100h.
// - Map CRC spans addresses 00h to 0Eh without status and control.
// - With map check on, compare map CRC to stored value and flag mismatch.
// - Map mismatch only sets its flag; writing one clears it.
// - Map check is enabled by a configuration bit included in the CRC.
// - Decode the two bytes right before the CRC byte; padding allowed.
// - Two zero bytes are a no-operation.
// - Read 40h plus address; data returns MSB first in the next frame.
// - Read of an unimplemented address returns 00h.
// - Register data is followed by zero bytes up to the data length.
// - Write 80h plus address with data, done in one frame; bad address ignored.
// - A new read command is accepted while previous register data shifts out.
// - A zero frame with a failing CRC sets the transfer error flag.
// - Status header shows the transfer error flag.
// - At chip select release decode only the last 16 or 24 input bits.
// - Mode 1: clock idles low, output on rising, input on falling edges.
module scc_top
  import scc_pkg::*;
#(
  parameter logic [7:0] REV_VALUE = 8'h5a  // Arbitrary revision value
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        sdi_i,
  input  wire logic [23:0] conv_data_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic [7:0]       conv_control_o,
  output logic [7:0]       config_reg_four_o,
  output logic             spi_err_o,
  output logic             reg_err_o
);

  // Link side: input shifter on falling edges
  logic [23:0] rx_shift_reg;
  logic [7:0]  rx_cnt_reg;

  // Link side: output shifter on rising edges
  logic [5:0]  bit_idx_reg;
  logic [7:0]  crc_out_reg;
  logic        sdo_reg;

  // System side
  logic        cs_meta_reg;
  logic        cs_sync_reg;
  logic        cs_prev_reg;
  logic [7:0]  cnt_seen_reg;
  logic        spi_err_reg;
  logic        reg_err_reg;
  logic        resp_pend_reg;
  logic [7:0]  resp_data_reg;
  logic [31:0] tx_word_reg;
  logic [5:0]  tx_bits_reg;
  logic        tx_crc_en_reg;
  logic [7:0]  regs_q [NUM_REGS];

  logic [15:0][7:0] map_vec;
  logic        frame_end;
  logic        crc_en;
  logic [7:0]  bits_got;
  logic        enough;
  logic [15:0] cmd;
  logic        crc_ok;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        is_read;
  logic        is_write;
  logic        exec;
  logic        crc_fail;
  logic        wr_en;
  logic        addr_ok;
  logic [7:0]  status_byte;
  logic [7:0]  map_crc;
  logic        map_mismatch;
  logic        spi_err_clr;
  logic        reg_err_clr;
  logic [23:0] data24;
  logic [31:0] tx_word_next;
  logic [5:0]  tx_bits_next;
  logic        tx_bit;

  function automatic logic [7:0] crc_cmd(input logic [15:0] c);
    logic [7:0] r;
    r = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      r = scc_crc_bit(r, c[i]);
    end
    return r;
  endfunction

  function automatic logic [7:0] crc_map(input logic [15:0][7:0] v);
    logic [7:0] r;
    r = CRC_INIT;
    for (int a = MAP_FIRST; a <= MAP_LAST; a++) begin
      if (a != int'(ADDR_STATUS) && a != int'(ADDR_CONTROL)) begin
        for (int b = 7; b >= 0; b--) begin
          r = scc_crc_bit(r, v[a][b]);
        end
      end
    end
    return r;
  endfunction

  // Input bits latched on falling edges; no reset, the window is read after the frame
  always_ff @(negedge sclk_i) begin
    rx_shift_reg <= {rx_shift_reg[22:0], sdi_i};
  end

  // System reset also clears the count; otherwise the first frame end reads an unknown length
  always_ff @(negedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_cnt_reg <= 8'h00;
    end else begin
      rx_cnt_reg <= rx_cnt_reg + 8'h01;
    end
  end

  // Output shifter, held in reset while chip select is high
  // System reset too, since chip select may already be high at power up with no edge
  always_ff @(posedge sclk_i or posedge cs_n_i or posedge sys_rst_i) begin
    if (cs_n_i || sys_rst_i) begin
      bit_idx_reg <= 6'h00;
    end else if (bit_idx_reg != 6'h3f) begin
      bit_idx_reg <= bit_idx_reg + 6'h01;
    end
  end

  assign tx_bit = tx_word_reg[5'd31 - bit_idx_reg[4:0]];

  always_ff @(posedge sclk_i or posedge cs_n_i or posedge sys_rst_i) begin
    if (cs_n_i || sys_rst_i) begin
      sdo_reg     <= 1'b0;
      crc_out_reg <= CRC_INIT;
    end else if (bit_idx_reg < tx_bits_reg) begin
      sdo_reg     <= tx_bit;
      crc_out_reg <= scc_crc_bit(crc_out_reg, tx_bit);
    end else if (tx_crc_en_reg && bit_idx_reg < tx_bits_reg + CRC_LEN_BITS) begin
      sdo_reg     <= crc_out_reg[7];
      crc_out_reg <= {crc_out_reg[6:0], 1'b0};
    end else begin
      sdo_reg     <= 1'b0;
    end
  end

  assign sdo_o    = sdo_reg;
  assign sdo_oe_o = ~cs_n_i;

  // Chip select crossing into the system clock
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_n_i;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  // Link registers are quiet once the clock has stopped and chip select is high
  assign frame_end = cs_sync_reg & ~cs_prev_reg;
  assign crc_en    = config_reg_four_o[CFG_SPI_CRC];
  assign bits_got  = rx_cnt_reg - cnt_seen_reg;
  assign enough    = bits_got >= (crc_en ? CMD_CRC_BITS : CMD_BITS);
  assign cmd       = crc_en ? rx_shift_reg[23:8] : rx_shift_reg[15:0];
  assign crc_ok    = ~crc_en | (crc_cmd(cmd) == rx_shift_reg[7:0]);
  assign addr      = cmd[11:8];
  assign wdata     = cmd[7:0];
  // Zero command bytes match neither pattern, so they fall through as no-op
  assign is_read   = cmd[15:12] == CMD_READ_NIB;
  assign is_write  = cmd[15:12] == CMD_WRITE_NIB;
  assign addr_ok   = addr <= ADDR_LAST;
  assign exec      = frame_end & enough & crc_ok;
  assign crc_fail  = frame_end & enough & ~crc_ok;
  assign wr_en     = exec & is_write & addr_ok &
                     (~spi_err_reg | (addr == ADDR_STATUS));

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_seen_reg <= 8'h00;
    end else if (frame_end) begin
      cnt_seen_reg <= rx_cnt_reg;
    end
  end

  // Register array; revision and status entries are not storage
  genvar g;
  for (g = 0; g < NUM_REGS; g++) begin : g_reg
    if (g == int'(ADDR_REV)) begin : g_rev
      assign regs_q[g] = REV_VALUE;
    end else if (g == int'(ADDR_STATUS)) begin : g_st
      assign regs_q[g] = status_byte;
    end else begin : g_rw
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          regs_q[g] <= REG_RESET;
        end else if (wr_en && addr == 4'(g)) begin
          regs_q[g] <= wdata;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      map_vec[i] = regs_q[i];
    end
  end

  assign conv_control_o    = regs_q[ADDR_CONTROL];
  assign config_reg_four_o = regs_q[ADDR_CFG4];

  // Map check runs every cycle; enable bit itself is part of the map
  assign map_crc      = crc_map(map_vec);
  assign map_mismatch = config_reg_four_o[CFG_REG_CRC] &
                        (map_crc != regs_q[ADDR_MAP_CRC]);

  assign spi_err_clr = wr_en & (addr == ADDR_STATUS) & wdata[ST_SPI_ERR];
  assign reg_err_clr = wr_en & (addr == ADDR_STATUS) & wdata[ST_REG_ERR];

  // Set beats clear so an error landing on the clear is kept
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      spi_err_reg <= 1'b0;
    end else begin
      spi_err_reg <= crc_fail | (spi_err_reg & ~spi_err_clr);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_err_reg <= 1'b0;
    end else begin
      reg_err_reg <= map_mismatch | (reg_err_reg & ~reg_err_clr);
    end
  end

  assign status_byte = {6'h00, reg_err_reg, spi_err_reg};
  assign spi_err_o   = spi_err_reg;
  assign reg_err_o   = reg_err_reg;

  // Read response is fetched at frame end and sent in the following frame
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      resp_pend_reg <= 1'b0;
      resp_data_reg <= 8'h00;
    end else if (frame_end) begin
      resp_pend_reg <= exec & is_read;
      resp_data_reg <= addr_ok ? regs_q[addr] : 8'h00;
    end
  end

  // Output frame layout, zero pad after register data
  assign data24 = resp_pend_reg ? {resp_data_reg, 16'h0000} : conv_data_i;

  always_comb begin
    tx_word_next = 32'h0000_0000;
    tx_bits_next = BITS_24;
    case ({config_reg_four_o[CFG_STATUS_EN], config_reg_four_o[CFG_RES16]})
      2'b00: begin
        tx_word_next = {data24, 8'h00};
        tx_bits_next = BITS_24;
      end
      2'b01: begin
        tx_word_next = {data24[23:8], 16'h0000};
        tx_bits_next = BITS_16;
      end
      2'b10: begin
        tx_word_next = {status_byte, data24};
        tx_bits_next = BITS_32;
      end
      default: begin
        tx_word_next = {status_byte, data24[23:8], 8'h00};
        tx_bits_next = BITS_24;
      end
    endcase
  end

  // Frozen while chip select is low so the link side sees stable words
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_word_reg   <= 32'h0000_0000;
      tx_bits_reg   <= BITS_24;
      tx_crc_en_reg <= 1'b0;
    end else if (cs_sync_reg && cs_prev_reg) begin
      tx_word_reg   <= tx_word_next;
      tx_bits_reg   <= tx_bits_next;
      tx_crc_en_reg <= crc_en;
    end
  end

endmodule

// ==== test/scc_top_monitor.sv ====
// Port-level checker for the serial command block, bound to scc_top.
`timescale 1ns/100ps
module scc_top_monitor
  import scc_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic        sdi_i,
  input wire logic [23:0] conv_data_i,
  input wire logic        sdo_o,
  input wire logic        sdo_oe_o,
  input wire logic [7:0]  conv_control_o,
  input wire logic [7:0]  config_reg_four_o,
  input wire logic        spi_err_o,
  input wire logic        reg_err_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  pin_enable_a: assert property (sdo_oe_o == !cs_n_i)
    else $error("output enable differs from select");
  idle_out_a: assert property (cs_n_i |-> !sdo_o)
    else $error("serial out active while deselected");
  out_edge_a: assert property (!$stable(sdo_o) |-> $rose(sclk_i) || !$stable(cs_n_i))
    else $error("serial out moved without a rising clock");
  err_set_a: assert property ($rose(spi_err_o) |-> cs_n_i && $past(cs_n_i, 3))
    else $error("transfer error set inside a frame");
  err_clear_a: assert property ($fell(spi_err_o) |-> cs_n_i && $past(cs_n_i, 3))
    else $error("transfer error cleared inside a frame");
  map_clear_a: assert property ($fell(reg_err_o) |-> cs_n_i && $past(cs_n_i, 3))
    else $error("map error cleared inside a frame");
  map_set_a: assert property ($rose(reg_err_o) |->
    $past(config_reg_four_o[CFG_REG_CRC]) || $past(config_reg_four_o[CFG_REG_CRC], 2))
    else $error("map error set with map check off");
  ctrl_write_a: assert property (!$stable(conv_control_o) |-> cs_n_i && $past(cs_n_i, 3))
    else $error("control changed inside a frame");
  cfg_write_a: assert property (!$stable(config_reg_four_o) |-> cs_n_i && $past(cs_n_i, 3))
    else $error("configuration changed inside a frame");
endmodule

bind scc_top scc_top_monitor scc_top_monitor_inst (.clk_sys_i, .sys_rst_i, .sclk_i, .cs_n_i,
  .sdi_i, .conv_data_i, .sdo_o, .sdo_oe_o, .conv_control_o, .config_reg_four_o, .spi_err_o,
  .reg_err_o);

// ==== test/scc_host_model.sv ====
// Host controller model: SPI mode 1 master sending 40-bit padded frames.
`timescale 1ns/100ps
module scc_host_model (
  input  wire logic clk_sys_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  logic crc_on = 1'b0;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // Start value all ones inverts the leading byte
  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // Pad bytes are not zero, so only the tail may be decoded
  task automatic xfer(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] mask,
                      output logic [39:0] dout);
    logic [39:0] din;
    din = crc_on ? {16'ha5a5, b1, b2, crc_byte(crc_byte(8'hff, b1), b2) ^ mask}
                 : {24'ha5a5a5, b1, b2};
    @(posedge clk_sys_i);
    #1 cs_n_o = 1'b0;
    // Edges kept off the system clock edges
    #16;
    for (int i = 39; i >= 0; i--) begin
      sclk_o = 1'b1;
      sdi_o = din[i];
      #6 sclk_o = 1'b0;
      dout[i] = sdo_i;
      #6;
    end
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the serial command block.
`timescale 1ns/100ps
module tb;
  import scc_pkg::*;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary revision value
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b0;
  logic        sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o, spi_err_o, reg_err_o;
  logic [23:0] conv_data_i = 24'h123456;
  logic [7:0]  conv_control_o, config_reg_four_o, rdat, mc;
  logic [39:0] frm;
  logic        stat_on = 1'b0;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  scc_top #(.REV_VALUE(REV)) scc_top_inst (.clk_sys_i, .sys_rst_i, .sclk_i, .cs_n_i, .sdi_i,
    .conv_data_i, .sdo_o, .sdo_oe_o, .conv_control_o, .config_reg_four_o, .spi_err_o,
    .reg_err_o);
  scc_host_model scc_host_model_inst (.clk_sys_i, .sdo_i(sdo_o), .sclk_o(sclk_i),
    .cs_n_o(cs_n_i), .sdi_o(sdi_i));

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xf(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] m = 8'h00);
    scc_host_model_inst.xfer(b1, b2, m, frm);
    rdat = stat_on ? frm[31:24] : frm[39:32];
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m = 8'h00);
    xf({CMD_WRITE_NIB, a}, d, m);
  endtask

  // Register data arrives in the frame after the command
  task automatic rd(input logic [3:0] a);
    xf({CMD_READ_NIB, a}, 8'h00);
    xf(8'h00, 8'h00);
  endtask

  function automatic logic [7:0] ocrc(input logic [31:0] w, input int n = 4);
    logic [7:0] c;
    c = 8'hff;
    for (int i = n - 1; i >= 0; i--)
      c = scc_host_model_inst.crc_byte(c, w[i*8 +: 8]);
    return c;
  endfunction

  task automatic complete_run;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    // A real rising edge so the link-side flops are cleared as well
    #1 sys_rst_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk({spi_err_o, reg_err_o, conv_control_o, config_reg_four_o}, 18'h0);
    rd(ADDR_REV);
    chk(rdat, REV);
    xf(8'h00, 8'h00);
    chk(rdat, 8'h12);
    wr(ADDR_CONTROL, 8'ha5);
    chk(conv_control_o, 8'ha5);
    wr(ADDR_REV, 8'hff);
    xf({CMD_READ_NIB, ADDR_CONTROL}, 8'h00);
    xf({CMD_READ_NIB, ADDR_REV}, 8'h00);
    chk(frm, {8'ha5, 32'h0});
    xf(8'h00, 8'h00);
    chk(rdat, REV);
    $display("test plain_access done");
    wr(ADDR_CFG4, 8'h05);
    chk(config_reg_four_o, 8'h05);
    scc_host_model_inst.crc_on = 1'b1;
    stat_on = 1'b1;
    chk(ocrc(32'h0000, 2), 8'hd7);
    rd(ADDR_CONTROL);
    chk(frm, {32'h00a50000, ocrc(32'h00a50000)});
    wr(ADDR_CONTROL, 8'h3c, 8'h01);
    chk({spi_err_o, conv_control_o}, {1'b1, 8'ha5});
    wr(ADDR_CONTROL, 8'h3c);
    chk(conv_control_o, 8'ha5);
    rd(ADDR_CONTROL);
    chk(frm[39:24], 16'h01a5);
    xf({CMD_READ_NIB, ADDR_CONTROL}, 8'h00, 8'h40);
    xf(8'h00, 8'h00);
    chk(rdat, 8'h12);
    wr(ADDR_STATUS, 8'h01);
    chk(spi_err_o, 1'b0);
    wr(ADDR_CONTROL, 8'h3c);
    chk(conv_control_o, 8'h3c);
    xf(8'h00, 8'h00, 8'hd7);
    chk(spi_err_o, 1'b1);
    wr(ADDR_STATUS, 8'h01);
    chk(spi_err_o, 1'b0);
    $display("test link_crc done");
    wr(ADDR_CFG4, 8'h09);
    xf(8'h00, 8'h00);
    chk(frm, {16'h1234, ocrc(32'h1234, 2), 16'h0000});
    wr(ADDR_CFG4, 8'h0d);
    rd(ADDR_CONTROL);
    chk(frm, {24'h003c00, ocrc(32'h003c00, 3), 8'h00});
    $display("test short_frame done");
    mc = 8'hff;
    for (int a = 0; a < 15; a++)
      if (a != 2 && a != 3)
        mc = scc_host_model_inst.crc_byte(mc, a == 0 ? REV : (a == 7 ? 8'h07 : 8'h00));
    wr(ADDR_MAP_CRC, mc);
    wr(ADDR_CFG4, 8'h07);
    wr(ADDR_CONTROL, 8'h99);
    chk({reg_err_o, config_reg_four_o}, 9'h007);
    wr(ADDR_MAP_CRC, ~mc);
    chk(reg_err_o, 1'b1);
    wr(ADDR_MAP_CRC, mc);
    chk({reg_err_o, conv_control_o}, 9'h199);
    wr(ADDR_STATUS, 8'h02);
    chk(reg_err_o, 1'b0);
    $display("test map_crc done");
    complete_run();
  end
endmodule
